// ---- logic/vic_pkg.sv ----
// Purpose: Constants and types for the vectored interrupt controller
// Assumes: 32-bit AHB-Lite register bus, 28 request channels
// Notes: Register offsets are byte addresses
// Behaviour
// - Sort each request into fast, vectored, plain
// - Class and slot changes apply at once
// - Fast class outranks every normal request
// - All fast requests ORed to one output
// - Readable word of active fast sources
// - Sixteen slots, any channel per slot
// - Slot 0 highest, slot 15 lowest
// - Non-vectored requests rank lowest
// - Normal output is OR of normal requests
// - Vector register gives winning slot or default
// - Readable word of active normal requests
// - One line per peripheral, flags ORed
// - Channels 0-3: watchdog, software, debug rx/tx
// - Channels 4,5: timers, four matches and captures
// - Channels 6,7: serial port causes
// - Channels 9-13: twi, sync ports, lock, clock
// - Channels 14-17 pins, 18 converter
// - Channel 19 filter, 20-27 CAN tx/rx pairs
package vic_pkg;
   localparam int NUM_CHAN = 28;
   localparam int NUM_SLOT = 16;
   localparam int SRC_W = 5;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h000;
   localparam logic [11:0] OFS_FIQ_STATUS = 12'h004;
   localparam logic [11:0] OFS_RAW_STATUS = 12'h008;
   localparam logic [11:0] OFS_CLASS_SEL = 12'h00C;
   localparam logic [11:0] OFS_ENABLE = 12'h010;
   localparam logic [11:0] OFS_SOFT_SET = 12'h018;
   localparam logic [11:0] OFS_SOFT_CLR = 12'h01C;
   localparam logic [11:0] OFS_VECT_NOW = 12'h030;
   localparam logic [11:0] OFS_DEFAULT_ADDR = 12'h034;
   localparam logic [11:0] OFS_SLOT_ADDR = 12'h100;
   localparam logic [11:0] OFS_SLOT_CTRL = 12'h200;
   localparam int CTRL_EN_BIT = 5;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic watchdog_request;
      logic debug_comm_receive;
      logic debug_comm_transmit;
      logic [3:0] timer0_match;
      logic [3:0] timer0_capture;
      logic [3:0] timer1_match;
      logic [3:0] timer1_capture;
      logic rx_line_status_cause0;
      logic tx_holding_empty_cause0;
      logic rx_data_available_cause0;
      logic char_timeout_cause0;
      logic rx_line_status_cause1;
      logic tx_holding_empty_cause1;
      logic rx_data_available_cause1;
      logic char_timeout_cause1;
      logic modem_status_cause1;
      logic [6:0] pwm_match;
      logic twi_state_change;
      logic sync_transfer_done0;
      logic sync_mode_fault0;
      logic sync_transfer_done1;
      logic sync_mode_fault1;
      logic synth_lock_request;
      logic clock_increment_request;
      logic clock_alarm_request;
      logic ext_irq_pin0;
      logic ext_irq_pin1;
      logic ext_irq_pin2;
      logic ext_irq_pin3;
      logic adc_request;
      logic can_filter_request;
      logic [3:0] can_tx;
      logic [3:0] can_rx;
   } periph_req_t;
endpackage

// ---- logic/vector_irq_controller.sv ----
// Purpose: Vectored interrupt controller with AHB-Lite registers
// Assumes: Requests are levels from logic on hclk
// Notes: Zero wait state slave; read data captured in address phase
`timescale 1ns/10ps
module vector_irq_controller (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire vic_pkg::periph_req_t periph_req,
   output logic fast_irq,
   output logic normal_irq
);
   import vic_pkg::*;

   logic [NUM_CHAN-1:0] line_req;
   logic [NUM_CHAN-1:0] line_q;
   logic [NUM_CHAN-1:0] class_q;
   logic [NUM_CHAN-1:0] enable_q;
   logic [NUM_CHAN-1:0] soft_q;
   logic [NUM_CHAN-1:0] raw_st;
   logic [NUM_CHAN-1:0] fiq_st;
   logic [NUM_CHAN-1:0] irq_st;
   logic [31:0] slot_addr_q [NUM_SLOT];
   logic [SRC_W:0] slot_ctrl_q [NUM_SLOT];
   logic [31:0] default_addr_q;
   logic [31:0] vect_d;
   logic [31:0] vect_q;
   logic [NUM_SLOT-1:0] slot_hit;
   logic [31:0] hrdata_q;
   logic fast_irq_q;
   logic normal_irq_q;
   logic wr_pend_q;
   logic [11:0] wr_addr_q;
   logic addr_ok;
   logic [31:0] rd_d;

   // One line per peripheral; flags of a peripheral are ORed
   always_comb begin
      line_req = '0;
      line_req[0] = periph_req.watchdog_request;
      line_req[1] = 1'b0;
      line_req[2] = periph_req.debug_comm_receive;
      line_req[3] = periph_req.debug_comm_transmit;
      line_req[4] = |{periph_req.timer0_match,
                      periph_req.timer0_capture};
      line_req[5] = |{periph_req.timer1_match,
                      periph_req.timer1_capture};
      line_req[6] = |{periph_req.rx_line_status_cause0,
                      periph_req.tx_holding_empty_cause0,
                      periph_req.rx_data_available_cause0,
                      periph_req.char_timeout_cause0};
      line_req[7] = |{periph_req.rx_line_status_cause1,
                      periph_req.tx_holding_empty_cause1,
                      periph_req.rx_data_available_cause1,
                      periph_req.char_timeout_cause1,
                      periph_req.modem_status_cause1};
      line_req[8] = |periph_req.pwm_match;
      line_req[9] = periph_req.twi_state_change;
      line_req[10] = periph_req.sync_transfer_done0 |
                     periph_req.sync_mode_fault0;
      line_req[11] = periph_req.sync_transfer_done1 |
                     periph_req.sync_mode_fault1;
      line_req[12] = periph_req.synth_lock_request;
      line_req[13] = periph_req.clock_increment_request |
                     periph_req.clock_alarm_request;
      line_req[14] = periph_req.ext_irq_pin0;
      line_req[15] = periph_req.ext_irq_pin1;
      line_req[16] = periph_req.ext_irq_pin2;
      line_req[17] = periph_req.ext_irq_pin3;
      line_req[18] = periph_req.adc_request;
      line_req[19] = periph_req.can_filter_request;
      for (int i = 0; i < 4; i++) begin
         line_req[20 + 2 * i] = periph_req.can_tx[i];
         line_req[21 + 2 * i] = periph_req.can_rx[i];
      end
   end

   // Levels only; a request stays up as long as its source holds it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         line_q <= '0;
      end else begin
         line_q <= line_req;
      end
   end

   // Settings are used live, so changes take effect next cycle
   assign raw_st = line_q | soft_q;
   assign fiq_st = raw_st & enable_q & class_q;
   assign irq_st = raw_st & enable_q & ~class_q;

   // Slot match: an enabled slot whose channel is a live normal request
   generate
      for (genvar s = 0; s < NUM_SLOT; s++) begin : g_slot
         logic [SRC_W-1:0] src;
         assign src = slot_ctrl_q[s][SRC_W-1:0];
         assign slot_hit[s] = slot_ctrl_q[s][CTRL_EN_BIT] &&
            (32'(src) < NUM_CHAN) && irq_st[src];
      end
   endgenerate

   // Lowest slot number wins; fall back to the shared default
   always_comb begin
      vect_d = default_addr_q;
      for (int s = NUM_SLOT - 1; s >= 0; s--) begin
         if (slot_hit[s]) begin
            vect_d = slot_addr_q[s];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vect_q <= RST_WORD;
      end else begin
         vect_q <= vect_d;
      end
   end

   // Fast line is separate from normal line, so fast is never masked
   // by normal traffic; the core gives its fast input precedence
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fast_irq_q <= 1'b0;
         normal_irq_q <= 1'b0;
      end else begin
         fast_irq_q <= |fiq_st;
         normal_irq_q <= |irq_st;
      end
   end

   // Bus slave: address phase decode, data phase write
   logic take;
   assign take = hsel && hready && htrans[1];
   assign addr_ok = (haddr[1:0] == 2'b00);

   always_comb begin
      rd_d = RST_WORD;
      if (haddr[11:8] == OFS_SLOT_ADDR[11:8]) begin
         if (haddr[7:6] == 2'b00) begin
            rd_d = slot_addr_q[haddr[5:2]];
         end
      end else if (haddr[11:8] == OFS_SLOT_CTRL[11:8]) begin
         if (haddr[7:6] == 2'b00) begin
            rd_d = 32'(slot_ctrl_q[haddr[5:2]]);
         end
      end else begin
         case (haddr[11:0])
            OFS_IRQ_STATUS: rd_d = 32'(irq_st);
            OFS_FIQ_STATUS: rd_d = 32'(fiq_st);
            OFS_RAW_STATUS: rd_d = 32'(raw_st);
            OFS_CLASS_SEL: rd_d = 32'(class_q);
            OFS_ENABLE: rd_d = 32'(enable_q);
            OFS_SOFT_SET: rd_d = 32'(soft_q);
            OFS_VECT_NOW: rd_d = vect_q;
            OFS_DEFAULT_ADDR: rd_d = default_addr_q;
            default: rd_d = RST_WORD;
         endcase
      end
      if (!addr_ok || haddr[31:12] != 20'h0_0000) begin
         rd_d = RST_WORD;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= RST_WORD;
      end else if (take && !hwrite) begin
         hrdata_q <= rd_d;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
      end else begin
         wr_pend_q <= take && hwrite && addr_ok &&
                      (haddr[31:12] == 20'h0_0000);
         if (take) begin
            wr_addr_q <= haddr[11:0];
         end
      end
   end

   // Class, enable and default vector; writable at any time
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         class_q <= '0;
         enable_q <= '0;
         default_addr_q <= RST_WORD;
      end else if (wr_pend_q) begin
         case (wr_addr_q)
            OFS_CLASS_SEL: class_q <= hwdata[NUM_CHAN-1:0];
            OFS_ENABLE: enable_q <= hwdata[NUM_CHAN-1:0];
            OFS_DEFAULT_ADDR: default_addr_q <= hwdata;
            default: ;
         endcase
      end
   end

   // Software requests; set wins if set and clear name the same bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         soft_q <= '0;
      end else if (wr_pend_q && wr_addr_q == OFS_SOFT_SET) begin
         soft_q <= soft_q | hwdata[NUM_CHAN-1:0];
      end else if (wr_pend_q && wr_addr_q == OFS_SOFT_CLR) begin
         soft_q <= soft_q & ~hwdata[NUM_CHAN-1:0];
      end
   end

   // Slot tables; any channel may go in any slot
   generate
      for (genvar s = 0; s < NUM_SLOT; s++) begin : g_tab
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               slot_addr_q[s] <= RST_WORD;
               slot_ctrl_q[s] <= '0;
            end else if (wr_pend_q) begin
               if (wr_addr_q == OFS_SLOT_ADDR + 12'(4 * s)) begin
                  slot_addr_q[s] <= hwdata;
               end
               if (wr_addr_q == OFS_SLOT_CTRL + 12'(4 * s)) begin
                  slot_ctrl_q[s] <= hwdata[SRC_W:0];
               end
            end
         end
      end
   endgenerate

   // Always ready, always OKAY; hsize is not checked, word assumed
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   assign hrdata = hrdata_q;
   assign fast_irq = fast_irq_q;
   assign normal_irq = normal_irq_q;
endmodule

// ---- bench/vic_sva.sv ----
// Purpose: Port assertions for the interrupt controller
// Assumes: Bound to the controller top
// Notes: One clock domain
`timescale 1ns/10ps
module vic_sva
   import vic_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire vic_pkg::periph_req_t periph_req,
   input wire logic fast_irq,
   input wire logic normal_irq
);
   logic wr, rd, wr_seen_q;
   logic [3:0] act_q;
   periph_req_t req_q;
   assign wr = hsel && hready && htrans[1] && hwrite;
   assign rd = hsel && hready && htrans[1] && !hwrite;
   // Recent input change or write: the only lawful causes of a line change
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_q <= '0;
         act_q <= 4'h0;
         wr_seen_q <= 1'b0;
      end else begin
         req_q <= periph_req;
         act_q <= {act_q[2:0], (periph_req != req_q) || wr};
         wr_seen_q <= wr_seen_q || wr;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   property p_ready; hreadyout == 1'b1; endproperty
   a_ready: assert property (p_ready) else $error("wait state seen");
   property p_rst; $rose(hresetn) |-> !fast_irq && !normal_irq; endproperty
   a_rst: assert property (p_rst) else $error("line high at reset");
   property p_unmap;
      rd && (haddr[31:12] != 20'h0 || haddr[1:0] != 2'h0) |=> hrdata == 0;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped data");
   property p_hold; !rd |=> $stable(hrdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_fcause; $changed(fast_irq) |-> act_q != 4'h0; endproperty
   a_fcause: assert property (p_fcause) else $error("fast moved");
   property p_ncause; $changed(normal_irq) |-> act_q != 4'h0; endproperty
   a_ncause: assert property (p_ncause) else $error("normal moved");
   property p_quiet; !wr_seen_q |-> !fast_irq && !normal_irq; endproperty
   a_quiet: assert property (p_quiet) else $error("line before setup");
endmodule

// ---- bench/core_model.sv ----
// Purpose: Processor side of the two request lines
// Assumes: Lines are levels on hclk
// Notes: Reports the entry the core would take
`timescale 1ns/10ps
module core_model (
   input wire logic hclk,
   input wire logic fast_irq,
   input wire logic normal_irq,
   output logic [1:0] entry_q
);
   always_ff @(posedge hclk) begin
      entry_q <= fast_irq ? 2'h2 : {1'b0, normal_irq};
   end
endmodule

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Zero wait state slave, level requests
// Notes: One flag stands for each tested channel
`timescale 1ns/10ps
module testbench;
   import vic_pkg::*;
   typedef struct packed {
      logic [4:0] a;
      logic [4:0] b;
      logic [31:0] vec;
   } row_t;
   localparam logic [31:0] DEF = 32'h0000_0D00;
   localparam logic [31:0] S0 = 32'hA000_0000;
   localparam logic [31:0] S15 = 32'hA000_000F;
   localparam logic [31:0] FAST = 32'h0000_0001;
   logic hclk, hresetn, hwrite, hready, hreadyout, hresp, fast_irq, normal_irq;
   logic [1:0] htrans, entry;
   logic [31:0] haddr, hwdata, hrdata, rd, mask;
   periph_req_t periph_req;
   int err_count, checked, i;
   row_t rows [9] = '{'{5'd0, 5'd0, DEF}, '{5'd14, 5'd14, S15},
      '{5'd27, 5'd27, S0}, '{5'd8, 5'd8, DEF}, '{5'd14, 5'd27, S0},
      '{5'd8, 5'd14, S15}, '{5'd4, 5'd7, DEF}, '{5'd19, 5'd17, DEF},
      '{5'd0, 5'd27, S0}};
   assign hready = hreadyout;
   vector_irq_controller uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .periph_req(periph_req),
      .fast_irq(fast_irq), .normal_irq(normal_irq));
   core_model core (.hclk(hclk), .fast_irq(fast_irq),
      .normal_irq(normal_irq), .entry_q(entry));
   function automatic periph_req_t to_req(input logic [31:0] m);
      periph_req_t r;
      r = '0;
      r.watchdog_request = m[0];
      r.timer0_capture[3] = m[4];
      r.modem_status_cause1 = m[7];
      r.pwm_match[6] = m[8];
      r.clock_alarm_request = m[13];
      r.ext_irq_pin0 = m[14];
      r.ext_irq_pin3 = m[17];
      r.can_filter_request = m[19];
      r.can_rx[3] = m[27];
      return r;
   endfunction
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   // Hang guard: ready never seen counts as a mismatch
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
         err_count++;
         $display("Error at %0t: ready never seen", $time);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a,
         input logic [31:0] d);
      @(posedge hclk);
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic wreg(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, {20'h0, a}, d);
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, {20'h0, a}, 32'h0);
      chk(rd, exp);
   endtask
   task automatic lines(input logic [1:0] exp);
      repeat (4) @(posedge hclk);
      chk({30'h0, fast_irq, normal_irq}, {30'h0, exp});
   endtask
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   initial begin
      hresetn = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      periph_req = '0;
      err_count = 0;
      checked = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      lines(2'h0);
      rchk(OFS_ENABLE, RST_WORD);
      wreg(OFS_ENABLE, 32'h0FFF_FFFF);
      // Upper bits alias the enable word; must still read zero
      bus(1'b0, 32'h0000_1010, 32'h0);
      chk(rd, 32'h0);
      wreg(OFS_CLASS_SEL, FAST);
      wreg(OFS_DEFAULT_ADDR, DEF);
      wreg(OFS_SLOT_ADDR, S0);
      wreg(OFS_SLOT_ADDR + 12'h03C, S15);
      wreg(OFS_SLOT_CTRL, 32'h0000_003B);
      wreg(OFS_SLOT_CTRL + 12'h03C, 32'h0000_002E);
      for (i = 0; i < 9; i++) begin
         mask = (32'h1 << rows[i].a) | (32'h1 << rows[i].b);
         periph_req <= to_req(mask);
         lines({|(mask & FAST), |(mask & ~FAST)});
         chk({30'h0, entry}, (mask & FAST) != 0 ? 32'h2 : 32'h1);
         rchk(OFS_FIQ_STATUS, mask & FAST);
         rchk(OFS_IRQ_STATUS, mask & ~FAST);
         rchk(OFS_VECT_NOW, rows[i].vec);
         $display("Row %0d done", i);
      end
      periph_req <= to_req(32'h0000_4000);
      wreg(OFS_CLASS_SEL, 32'h0000_4000);
      lines(2'h2);
      rchk(OFS_VECT_NOW, DEF);
      periph_req <= to_req(32'h0000_4001);
      wreg(OFS_CLASS_SEL, 32'h0000_4001);
      lines(2'h2);
      rchk(OFS_FIQ_STATUS, 32'h0000_4001);
      wreg(OFS_ENABLE, 32'h0);
      lines(2'h0);
      rchk(OFS_RAW_STATUS, 32'h0000_4001);
      $display("Reclass done");
      bus(1'b1, 32'h0000_1010, 32'hFFFF_FFFF);
      rchk(OFS_ENABLE, 32'h0);
      periph_req <= '0;
      wreg(OFS_ENABLE, 32'h0000_0002);
      wreg(OFS_SOFT_SET, 32'h0000_0002);
      lines(2'h1);
      rchk(OFS_IRQ_STATUS, 32'h0000_0002);
      wreg(OFS_SOFT_CLR, 32'h0000_0002);
      lines(2'h0);
      $display("Soft channel done");
      // Reset in mid-run with a live request must clear everything
      wreg(OFS_SOFT_SET, 32'h0000_0002);
      lines(2'h1);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk({29'h0, hreadyout, fast_irq, normal_irq}, 32'h4);
      hresetn <= 1'b1;
      lines(2'h0);
      rchk(OFS_RAW_STATUS, RST_WORD);
      rchk(OFS_ENABLE, RST_WORD);
      $display("Mid-run reset done");
      print_verdict();
   end
endmodule
bind vector_irq_controller vic_sva chk_i (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .periph_req(periph_req),
   .fast_irq(fast_irq), .normal_irq(normal_irq));
